// file: src/lcd_timing_cfg.svh
// constants for the panel scan timing and start address block
// assumes an 8-bit index/data register pair on a 16-bit i/o address
`ifndef LCD_TIMING_CFG_SVH
`define LCD_TIMING_CFG_SVH

// i/o port addresses of the index and data registers
`define IO_ADDR_W          16
`define IO_INDEX_ADDR      16'h03D4
`define IO_DATA_ADDR       16'h03D5

// indexed register numbers
`define IDX_START_HIGH     8'h0C
`define IDX_START_LOW      8'h0D
`define IDX_TIMING_ONE     8'hC6
`define IDX_TIMING_TWO     8'hC7

// field positions
`define START_HIGH_MSB     6
`define START_LOW_MSB      7
`define START_LOW_LSB      3
`define PRESCALE_MSB       7
`define PRESCALE_LSB       5
`define PERIOD_MSB         4
`define HIGH_MSB           4
`define WIDTH_MSB          6
`define WIDTH_LSB          5

// reset values
`define START_HIGH_RST     7'h00
`define START_LOW_RST      5'h00
`define PRESCALE_RST       3'h0
`define PERIOD_RST         5'h00
`define HIGH_RST           5'h00
`define WIDTH_RST          2'h0
`define INDEX_RST          8'h00

// prescale counter covers the largest divisor, 2**7
`define PRESCALE_CNT_W     7
`define START_ADDR_W       15

`endif

// file: src/lcd_timing_pkg.sv
// types shared by the panel scan timing block
// assumes lcd_timing_cfg.svh for the numeric constants
package lcd_timing_pkg;

  // panel data bus width codes
  typedef enum logic [1:0] {
    WIDTH_FOUR = 2'b00,
    WIDTH_TWO  = 2'b01,
    WIDTH_ONE  = 2'b10,
    WIDTH_RSVD = 2'b11
  } panel_width_type;

  typedef logic [7:0] pixel_byte_type;

endpackage

// file: src/pixel_stream_if.sv
// byte stream carrier with valid/ready between the block's own modules
// assumes source and sink share one clock
`timescale 1ns/1ns
interface pixel_stream_if;
  import lcd_timing_pkg::*;

  logic           valid;
  logic           ready;
  pixel_byte_type data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// file: src/pclk_prescaler.sv
// pixel clock prescaler: one-cycle tick every 2**sel input clocks
// assumes the input clock is the divided oscillator clock
`timescale 1ns/1ns
`include "lcd_timing_cfg.svh"
module pclk_prescaler
  import lcd_timing_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [2:0] sel_in,
  output logic            tick_out
);

  logic [`PRESCALE_CNT_W-1:0] cnt_r;
  logic [`PRESCALE_CNT_W-1:0] mask;

  // free-running count; a changed divisor takes effect without a restart
  assign mask     = ~(7'h7F << sel_in);
  assign tick_out = &(cnt_r | ~mask);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end

endmodule

// file: src/pixel_buffer.sv
// two-entry buffer for pixel bytes on the way to the shifter
// assumes both sides follow valid/ready; a word moves when both are high
`timescale 1ns/1ns
module pixel_buffer
  import lcd_timing_pkg::*;
(
  input  wire logic   clk_in,
  input  wire logic   rst_in,
  pixel_stream_if.snk in_s,
  pixel_stream_if.src out_s
);

  pixel_byte_type mem_r [2];
  logic           wr_ptr_r;
  logic           rd_ptr_r;
  logic [1:0]     count_r;
  logic           push;
  logic           pop;

  assign in_s.ready  = (count_r != 2'd2);
  assign out_s.valid = (count_r != 2'd0);
  assign out_s.data  = mem_r[rd_ptr_r];
  assign push        = in_s.valid & in_s.ready;
  assign pop         = out_s.valid & out_s.ready;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_s.data;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r  <= 2'd0;
    end else begin
      wr_ptr_r <= wr_ptr_r ^ push;
      rd_ptr_r <= rd_ptr_r ^ pop;
      count_r  <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule

// file: src/lcd_scan_timing.sv
// panel scan timing core: start address, pixel clock prescale,
// shift clock generation and 4/2/1-bit panel data serialiser
// assumes an i/o bus with one-cycle read/write strobes, synchronous to clk_in,
// and a fetch source that supplies pixel bytes with valid/ready
`timescale 1ns/1ns
`include "lcd_timing_cfg.svh"
module lcd_scan_timing
  import lcd_timing_pkg::*;
(
  input  wire logic                     clk_in,
  input  wire logic                     rst_in,
  input  wire logic [`IO_ADDR_W-1:0]    io_addr_in,
  input  wire logic                     io_wr_in,
  input  wire logic                     io_rd_in,
  input  wire logic [7:0]               io_wdata_in,
  output logic      [7:0]               io_rdata_out,
  input  wire logic                     pix_valid_in,
  output logic                          pix_ready_out,
  input  wire logic [7:0]               pix_data_in,
  output logic      [`START_ADDR_W-1:0] display_start_addr_out,
  output logic                          pclk_tick_out,
  output logic                          panel_shift_clock_out,
  output logic      [3:0]               panel_data_out
);

  // ---------------- register file ----------------
  logic [7:0]      index_r;
  logic [6:0]      start_high_r;
  logic [4:0]      start_low_r;
  logic [2:0]      prescale_r;
  logic [4:0]      period_r;
  logic [4:0]      high_r;
  logic [1:0]      width_r;
  logic [7:0]      rdata_r;

  logic            sel_index;
  logic            sel_data;
  logic            wr_index;
  logic            wr_data;
  logic            hit_high;
  logic            hit_low;
  logic            hit_t1;
  logic            hit_t2;
  logic [7:0]      data_rd_val;
  logic [7:0]      rd_val;

  assign sel_index = (io_addr_in == `IO_INDEX_ADDR);
  assign sel_data  = (io_addr_in == `IO_DATA_ADDR);
  assign wr_index  = io_wr_in & sel_index;
  assign wr_data   = io_wr_in & sel_data;

  // the data port acts on whatever the index currently selects
  assign hit_high = (index_r == `IDX_START_HIGH);
  assign hit_low  = (index_r == `IDX_START_LOW);
  assign hit_t1   = (index_r == `IDX_TIMING_ONE);
  assign hit_t2   = (index_r == `IDX_TIMING_TWO);

  // reserved bits read back as zero; unknown indices read zero
  assign data_rd_val = hit_high ? {1'b0, start_high_r} :
                       hit_low  ? {start_low_r, 3'b000} :
                       hit_t1   ? {prescale_r, period_r} :
                       hit_t2   ? {1'b0, width_r, high_r} :
                                  8'h00;
  assign rd_val = sel_index ? index_r :
                  sel_data  ? data_rd_val :
                              8'h00;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      index_r <= `INDEX_RST;
    end else if (wr_index) begin
      index_r <= io_wdata_in;
    end
  end

  // bit 7 of the high register and bits 2..0 of the low one are not stored
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      start_high_r <= `START_HIGH_RST;
      start_low_r  <= `START_LOW_RST;
    end else if (wr_data & hit_high) begin
      start_high_r <= io_wdata_in[`START_HIGH_MSB:0];
    end else if (wr_data & hit_low) begin
      start_low_r  <= io_wdata_in[`START_LOW_MSB:`START_LOW_LSB];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prescale_r <= `PRESCALE_RST;
      period_r   <= `PERIOD_RST;
      high_r     <= `HIGH_RST;
      width_r    <= `WIDTH_RST;
    end else if (wr_data & hit_t1) begin
      prescale_r <= io_wdata_in[`PRESCALE_MSB:`PRESCALE_LSB];
      period_r   <= io_wdata_in[`PERIOD_MSB:0];
    end else if (wr_data & hit_t2) begin
      width_r    <= io_wdata_in[`WIDTH_MSB:`WIDTH_LSB];
      high_r     <= io_wdata_in[`HIGH_MSB:0];
    end
  end

  // read data is registered; it stands until the next read strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_r <= 8'h00;
    end else if (io_rd_in) begin
      rdata_r <= rd_val;
    end
  end

  assign io_rdata_out = rdata_r;

  // low three address bits are always zero: fetch starts on an 8-byte boundary
  assign display_start_addr_out = {start_high_r, start_low_r, 3'b000};

  // ---------------- pixel clock ----------------
  logic pclk_tick;

  pclk_prescaler u_prescaler (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .sel_in   (prescale_r),
    .tick_out (pclk_tick)
  );

  assign pclk_tick_out = pclk_tick;

  // ---------------- pixel buffer ----------------
  pixel_stream_if fill_s ();
  pixel_stream_if drain_s ();

  assign fill_s.valid  = pix_valid_in;
  assign fill_s.data   = pix_data_in;
  assign pix_ready_out = fill_s.ready;

  pixel_buffer u_buffer (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .in_s   (fill_s),
    .out_s  (drain_s)
  );

  // ---------------- shift clock ----------------
  logic [4:0] phase_r;
  logic [4:0] phase_nxt;
  logic       shift_clk_r;
  logic       period_start;

  // a period of zero would make every pixel clock a new period; software avoids it
  assign phase_nxt    = (phase_r >= period_r) ? 5'd0 : phase_r + 5'd1;
  assign period_start = pclk_tick & (phase_nxt == 5'd0);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      phase_r     <= 5'd0;
      shift_clk_r <= 1'b0;
    end else if (pclk_tick) begin
      phase_r     <= phase_nxt;
      // high for phases 0..high field, so high time is field plus one
      shift_clk_r <= (phase_nxt <= high_r);
    end
  end

  assign panel_shift_clock_out = shift_clk_r;

  // ---------------- serialiser ----------------
  panel_width_type width_mode;
  logic [7:0]      shreg_r;
  logic [2:0]      groups_left_r;
  logic [3:0]      data_r;
  logic [2:0]      groups_per_byte;
  logic            need_byte;
  logic            take_byte;
  logic [7:0]      src_byte;
  logic [3:0]      group_out;
  logic [7:0]      src_shifted;

  // the reserved width code is run as the 4-line default
  assign width_mode = panel_width_type'(width_r);
  assign groups_per_byte = (width_mode == WIDTH_TWO) ? 3'd4 :
                           (width_mode == WIDTH_ONE) ? 3'd7 :
                                                       3'd2;
  assign need_byte = (groups_left_r == 3'd0);
  assign take_byte = period_start & need_byte & drain_s.valid;
  assign drain_s.ready = period_start & need_byte;
  assign src_byte  = need_byte ? drain_s.data : shreg_r;

  // msb first; unused data lines are held low
  assign group_out = (width_mode == WIDTH_TWO) ? {2'b00, src_byte[7:6]} :
                     (width_mode == WIDTH_ONE) ? {3'b000, src_byte[7]} :
                                                 src_byte[7:4];
  assign src_shifted = (width_mode == WIDTH_TWO) ? {src_byte[5:0], 2'b00} :
                       (width_mode == WIDTH_ONE) ? {src_byte[6:0], 1'b0} :
                                                   {src_byte[3:0], 4'h0};

  // one-bit mode has eight groups; groups_left counts those still to send
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shreg_r       <= 8'h00;
      groups_left_r <= 3'd0;
      data_r        <= 4'h0;
    end else if (period_start) begin
      if (!need_byte) begin
        data_r        <= group_out;
        shreg_r       <= src_shifted;
        groups_left_r <= groups_left_r - 3'd1;
      end else if (take_byte) begin
        data_r        <= group_out;
        shreg_r       <= src_shifted;
        groups_left_r <= (width_mode == WIDTH_ONE) ? groups_per_byte : groups_per_byte - 3'd1;
      end else begin
        // underrun: lines go idle rather than repeat stale pixels
        data_r <= 4'h0;
      end
    end
  end

  assign panel_data_out = data_r;

endmodule

// file: testbench/lcd_scan_timing_checker.sv
// port-level assertions for lcd_scan_timing
// assumes it is bound to the design and sees only the top module's ports
`timescale 1ns/1ns
`include "lcd_timing_cfg.svh"
module lcd_scan_timing_checker
  import lcd_timing_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [15:0] io_addr_in,
  input wire logic        io_wr_in,
  input wire logic        io_rd_in,
  input wire logic [7:0]  io_wdata_in,
  input wire logic [7:0]  io_rdata_out,
  input wire logic [14:0] display_start_addr_out,
  input wire logic        pclk_tick_out,
  input wire logic        panel_shift_clock_out,
  input wire logic [3:0]  panel_data_out
);
  logic [7:0] idx_r;
  logic [7:0] sh_r [256];
  logic [7:0] since_r;
  logic [7:0] gap_r;
  logic [5:0] hcnt_r;
  logic [5:0] pcnt_r;
  logic       shd_r;
  wire  [7:0] t1 = sh_r[`IDX_TIMING_ONE];
  wire  [7:0] t2 = sh_r[`IDX_TIMING_TWO];
  wire        quiet = since_r == 8'hFF;
  wire        rose_sh = panel_shift_clock_out && !shd_r;
  wire  [7:0] msk = idx_r == `IDX_START_HIGH ? 8'h7F : idx_r == `IDX_START_LOW ? 8'hF8 :
                    idx_r == `IDX_TIMING_ONE ? 8'hFF : idx_r == `IDX_TIMING_TWO ? 8'h7F : 8'h00;
  wire  [7:0] rd_val = sh_r[idx_r] & msk;
  // shadow of the indexed registers, so reads and timing are judged against what was written
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      idx_r <= 8'h00;
      for (int i = 0; i < 256; i++) sh_r[i] <= 8'h00;
    end else if (io_wr_in && io_addr_in == `IO_INDEX_ADDR) begin
      idx_r <= io_wdata_in;
    end else if (io_wr_in && io_addr_in == `IO_DATA_ADDR) begin
      sh_r[idx_r] <= io_wdata_in;
    end
  end
  // timing checks wait for 255 quiet cycles: a config change may cut a period short
  always_ff @(posedge clk_in) begin
    shd_r <= panel_shift_clock_out;
    since_r <= (rst_in || io_wr_in) ? 8'h00 : since_r + {7'h00, !quiet};
    gap_r <= pclk_tick_out ? 8'h00 : gap_r + 8'h01;
    hcnt_r <= !panel_shift_clock_out ? 6'h00 : hcnt_r + {5'h00, pclk_tick_out};
    pcnt_r <= rose_sh ? {5'h00, pclk_tick_out} : pcnt_r + {5'h00, pclk_tick_out};
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  property p_reset_vals; $fell(rst_in) |-> display_start_addr_out == 15'h0000 && io_rdata_out == 8'h00
    && panel_data_out == 4'h0 && !panel_shift_clock_out; endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("outputs not cleared by reset");
  property p_start_addr; display_start_addr_out == {sh_r[`IDX_START_HIGH][6:0], sh_r[`IDX_START_LOW][7:3], 3'h0};
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start address differs");
  property p_read_data; io_rd_in && io_addr_in == `IO_DATA_ADDR |=> io_rdata_out == $past(rd_val); endproperty
  a_read_data: assert property (p_read_data) else $error("indexed read data wrong");
  property p_read_hold; !io_rd_in |=> $stable(io_rdata_out); endproperty
  a_read_hold: assert property (p_read_hold) else $error("read data moved without a read");
  property p_tick_gap; quiet && pclk_tick_out |-> gap_r == (8'h01 << t1[7:5]) - 8'h01; endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("pixel clock spacing wrong");
  property p_period; quiet && rose_sh |-> pcnt_r == t1[4:0] + 6'h01; endproperty
  a_period: assert property (p_period) else $error("shift period wrong");
  property p_high; quiet && $fell(panel_shift_clock_out) |-> hcnt_r == t2[4:0] + 6'h01; endproperty
  a_high: assert property (p_high) else $error("shift high time wrong");
  property p_width; quiet |-> (t2[6:5] == 2'b01 ? panel_data_out[3:2] == 2'b00 :
    t2[6:5] == 2'b10 ? panel_data_out[3:1] == 3'b000 : 1'b1); endproperty
  a_width: assert property (p_width) else $error("unused panel lines not idle");
endmodule
bind lcd_scan_timing lcd_scan_timing_checker chk (.clk_in(clk_in), .rst_in(rst_in), .io_addr_in(io_addr_in),
  .io_wr_in(io_wr_in), .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out),
  .display_start_addr_out(display_start_addr_out), .pclk_tick_out(pclk_tick_out),
  .panel_shift_clock_out(panel_shift_clock_out), .panel_data_out(panel_data_out));

// file: testbench/panel_model.sv
// passive panel: queues the data group present at each falling shift clock edge
// assumes shift clock and data come from the design on the same clk_in
`timescale 1ns/1ns
module panel_model (
  input wire logic       clk_in,
  input wire logic       shift_in,
  input wire logic [3:0] data_in
);
  logic       shd_r;
  logic [3:0] groups[$];
  // latching on the fall gives the data the whole high time to settle
  always @(posedge clk_in) begin
    shd_r <= shift_in;
    if (shd_r && !shift_in) groups.push_back(data_in);
  end
endmodule

// file: testbench/testbench.sv
// bench for lcd_scan_timing: indexed registers, pixel clock rates, panel streams
// assumes the bound checker and panel_model
`timescale 1ns/1ns
`include "lcd_timing_cfg.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module testbench;
  logic        clk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [15:0] io_addr_in = 16'h0000;
  logic        io_wr_in = 1'b0;
  logic        io_rd_in = 1'b0;
  logic [7:0]  io_wdata_in = 8'h00;
  logic [7:0]  io_rdata_out;
  logic        pix_valid_in = 1'b0;
  logic        pix_ready_out;
  logic [7:0]  pix_data_in = 8'h00;
  logic [14:0] display_start_addr_out;
  logic        pclk_tick_out;
  logic        panel_shift_clock_out;
  logic [3:0]  panel_data_out;
  int          errors = 0;
  int          num_checks = 0;
  int          n;
  lcd_scan_timing dut (.clk_in(clk_in), .rst_in(rst_in), .io_addr_in(io_addr_in), .io_wr_in(io_wr_in),
    .io_rd_in(io_rd_in), .io_wdata_in(io_wdata_in), .io_rdata_out(io_rdata_out), .pix_valid_in(pix_valid_in),
    .pix_ready_out(pix_ready_out), .pix_data_in(pix_data_in), .display_start_addr_out(display_start_addr_out),
    .pclk_tick_out(pclk_tick_out), .panel_shift_clock_out(panel_shift_clock_out), .panel_data_out(panel_data_out));
  panel_model pm (.clk_in(clk_in), .shift_in(panel_shift_clock_out), .data_in(panel_data_out));
  initial forever #10 clk_in = ~clk_in;
  task automatic bus(input logic [15:0] a, input logic wr, input logic [7:0] d);
    @(posedge clk_in);
    io_addr_in <= a;
    io_wdata_in <= d;
    io_wr_in <= wr;
    io_rd_in <= !wr;
    @(posedge clk_in);
    io_wr_in <= 1'b0;
    io_rd_in <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] idx, input logic [7:0] d);
    bus(`IO_INDEX_ADDR, 1'b1, idx);
    bus(`IO_DATA_ADDR, 1'b1, d);
  endtask
  task automatic rreg(input logic [7:0] idx, input logic [7:0] e);
    bus(`IO_INDEX_ADDR, 1'b1, idx);
    bus(`IO_DATA_ADDR, 1'b0, 8'h00);
    @(negedge clk_in);
    `CHK(io_rdata_out, e)
  endtask
  task automatic tick_gap(output int cnt);
    cnt = 0;
    do begin
      @(negedge clk_in);
      cnt++;
    end while (pclk_tick_out !== 1'b1);
  endtask
  task automatic xfer(input int w, input logic [7:0] b[$], output int stalls);
    logic [3:0] g;
    stalls = 0;
    repeat (300) @(posedge clk_in);
    pm.groups.delete();
    foreach (b[i]) begin
      pix_valid_in <= 1'b1;
      pix_data_in <= b[i];
      @(negedge clk_in);
      while (pix_ready_out !== 1'b1) begin
        stalls++;
        @(negedge clk_in);
      end
      @(posedge clk_in);
    end
    pix_valid_in <= 1'b0;
    repeat (600) @(posedge clk_in);
    while (pm.groups.size() > 0 && pm.groups[0] == 4'h0) void'(pm.groups.pop_front());
    foreach (b[i]) for (int j = 0; j < 8 / w; j++) begin
      g = pm.groups.pop_front();
      `CHK(g, 4'((b[i] >> (8 - w * (j + 1))) & ((1 << w) - 1)))
    end
    $display("test stream width %0d done", w);
  endtask
  task automatic stop_test;
    $display("checks %0d, mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #1000000;
    errors++;
    stop_test();
  end
  initial begin
    repeat (2) @(posedge clk_in);
    rst_in <= 1'b0;
    rreg(`IDX_START_HIGH, 8'h00);
    rreg(`IDX_START_LOW, 8'h00);
    rreg(`IDX_TIMING_ONE, 8'h00);
    rreg(`IDX_TIMING_TWO, 8'h00);
    $display("test reset values done");
    wreg(`IDX_START_HIGH, 8'h7F);
    wreg(`IDX_START_LOW, 8'hF8);
    wreg(8'h55, 8'h3C);
    rreg(`IDX_START_HIGH, 8'h7F);
    rreg(`IDX_START_LOW, 8'hF8);
    rreg(8'h55, 8'h00);
    `CHK(display_start_addr_out, 15'h7FF8)
    wreg(`IDX_START_LOW, 8'h50);
    bus(16'h03D0, 1'b0, 8'h00);
    @(negedge clk_in);
    `CHK(io_rdata_out, 8'h00)
    `CHK(display_start_addr_out, 15'h7F50)
    wreg(`IDX_TIMING_TWO, 8'h21);
    rreg(`IDX_TIMING_TWO, 8'h21);
    $display("test registers done");
    for (int c = 0; c < 8; c++) begin
      wreg(`IDX_TIMING_ONE, {c[2:0], 5'h03});
      tick_gap(n);
      tick_gap(n);
      tick_gap(n);
      `CHK(n, 1 << c)
    end
    $display("test prescale done");
    wreg(`IDX_TIMING_ONE, 8'h23);
    wreg(`IDX_TIMING_TWO, 8'h01);
    xfer(4, '{8'hA5, 8'h3C, 8'h96, 8'h5A}, n);
    `CHK(n > 0, 1'b1)
    wreg(`IDX_TIMING_TWO, 8'h21);
    xfer(2, '{8'hC6, 8'h39}, n);
    wreg(`IDX_TIMING_TWO, 8'h41);
    xfer(1, '{8'h81, 8'h7E}, n);
    stop_test();
  end
endmodule
